// ===== rtl/dram_register_space_access.sv
/*
 holds the register-space access logic of the x16 ddr pseudo-static dram:
 command/address capture, space and register decode, identification and
 configuration words, zero-latency register writes and latency-timed reads.
 assumes the link clock, chip select and data lanes arrive from the host
 asynchronously and are sampled by clk, which runs well above the link rate.
*/
`default_nettype none

// How it works
// - command/address bit 46 set sends the transaction to register space.
// - memory accesses take half-page from bits 20-16, word from bits 2-0.
// - a row is 32 half-pages of eight double words, 256 in all.
// - identification words read with c0h/e0h, lowest byte 00h or 01h.
// - config word 0 at bits 31-24 = 01h; read c0h/e0h, write 60h.
// - config word 1 same, but lowest byte 01h.
// - register reads ignore the burst-type bit; c0h equals e0h.
// - two read-only 16-bit identification words: word 0 reports the part geometry, word 1 the device type.
// - identification word 0 holds row bit count 01110b in bits 12-8.
// - identification word 0 holds column count 0111b and a maker code.
// - every register takes its default on reset.
// - register writes are accepted whenever the device is in standby.
// - register write is one 16-bit word right after the last address cycle.
// - strobe shows refresh during address cycles without affecting writes.
// - strobe released after address cycles; both bytes written, no mask.
// - register read waits one or two latency counts from config word 0.
// - register data on low lane, upper byte on rise, lower on fall.
// - bit 47 clear means write, set means read.
module dram_register_space_access #(
   parameter logic [3:0] MAKER_CODE = 4'h5, // arbitrary value
   parameter logic [3:0] DEVICE_TYPE = 4'h3 // arbitrary value
) (
   input wire logic clk, // device clock, 20 MHz
   input wire logic rst_n, // synchronous reset, active low
   input wire logic clkEn, // freezes all state while low
   input wire logic linkClk, // link clock from host
   input wire logic chipSelect_n, // chip select, active low
   input wire logic [15:0] dqIn, // data lanes from host
   input wire logic rwDataStrobeIn, // strobe level seen on the pin
   input wire logic refreshBusy, // array refresh in progress
   output logic [7:0] dqOut, // low data lane toward host
   output logic dqOe, // low data lane enable
   output logic rwDataStrobeOut, // strobe driven by device
   output logic rwDataStrobeOe, // strobe enable
   output dram_regs_pkg::mem_addr_t memAddr, // decoded array address
   output logic memStart, // pulse: array access decoded
   output logic memIsRead, // array access direction
   output logic [15:0] configWord0, // config word 0 contents
   output logic [15:0] configWord1 // config word 1 contents
);
   import dram_regs_pkg::*;

   // --------------------------------------------------------------
   // elaboration checks
   // --------------------------------------------------------------
   // the decode slices fixed byte lanes and the carrier has fixed field
   // widths, so a package that moves a field must fail here, not in silicon
   if (CA_WIDTH != 48) begin : g_chk_ca
      $error("command word must be 48 bits");
   end

   if (ROW_MSB - ROW_LSB + 1 != 15) begin : g_chk_row
      $error("row field must be 15 bits");
   end

   if (HP_MSB - HP_LSB + 1 != 5 || HALF_PAGES_PER_ROW != 32) begin : g_chk_hp
      $error("half-page field must be 5 bits");
   end

   if (WORD_MSB - WORD_LSB + 1 != 3 || WORDS_PER_HALF_PAGE != 8) begin : g_chk_word
      $error("word field must be 3 bits");
   end

   if (DWORDS_PER_ROW != 256) begin : g_chk_dwords
      $error("row must hold 256 double words");
   end

   if (CFG0_LAT_MSB - CFG0_LAT_LSB + 1 != 4) begin : g_chk_lat
      $error("latency field must be 4 bits");
   end

   // the address edge counter is three bits wide
   if (CAW_CYCLES < 1 || 2 * CAW_CYCLES > 8) begin : g_chk_caw
      $error("address cycle count out of range");
   end

   if (CA_READ_BIT != 47 || CA_SPACE_BIT != 46 || CA_BURST_BIT != 45) begin : g_chk_bits
      $error("command bits must be 47 to 45");
   end

   // --------------------------------------------------------------
   // synchronisers and edge finding
   // --------------------------------------------------------------
   logic [1:0] ckSync_q, csSync_q;
   logic [15:0] dqS1_q, dqS2_q;
   logic ckPrev_q;
   // reset levels match the idle pins, so no false edge or select follows reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ckSync_q <= 2'h0;
         csSync_q <= 2'h3;
         ckPrev_q <= 1'b0;
      end else if (clkEn) begin
         ckSync_q <= {ckSync_q[0], linkClk};
         csSync_q <= {csSync_q[0], chipSelect_n};
         ckPrev_q <= ckSync_q[1];
      end
   end
   // data bits lag exactly as far as the clock edge finder does
   for (genvar b = 0; b < 16; b++) begin : g_dq_sync
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            dqS1_q[b] <= 1'b0;
            dqS2_q[b] <= 1'b0;
         end else if (clkEn) begin
            dqS1_q[b] <= dqIn[b];
            dqS2_q[b] <= dqS1_q[b];
         end
      end
   end
   wire logic ck = ckSync_q[1];
   wire logic csActive = !csSync_q[1];
   wire logic ckRise = ck && !ckPrev_q;
   wire logic ckFall = !ck && ckPrev_q;
   wire logic ckEdge = ckRise || ckFall;

   // --------------------------------------------------------------
   // transaction sequencing
   // --------------------------------------------------------------
   // idle -> address -> write data or latency -> read data; array
   // accesses and finished writes park in done until chip select rises,
   // which is the only way back to idle, so a cut frame never leaves a
   // half-taken command behind
   typedef enum logic [2:0] { ST_IDLE, ST_CA, ST_WDATA, ST_LAT, ST_RDATA, ST_DONE } state_t;
   state_t state_q;
   logic wrHit_q;
   logic [2:0] caCnt_q;
   logic [CA_WIDTH-1:0] ca_q;
   logic [7:0] wrHi_q;
   logic wrHalf_q;
   logic extraLat_q;
   logic [5:0] latCnt_q;
   logic [1:0] rdCnt_q;
   logic [15:0] rdWord_q;
   cmd_decode_t dec;
   logic [7:0] top;
   logic [3:0] latCode;
   logic [5:0] latClocks;

   // the low lane carries the byte; upper lane ignored during address
   wire logic [CA_WIDTH-1:0] caNext = {ca_q[CA_WIDTH-9:0], dqS2_q[7:0]};
   wire logic caLast = ckEdge && caCnt_q == 3'(2 * CAW_CYCLES - 1);

   always_comb begin
      top = caNext[47:40];
      dec = '0;
      dec.valid = caLast;
      dec.isRead = caNext[CA_READ_BIT];
      dec.isReg = caNext[CA_SPACE_BIT];
      // burst bit excluded from read match so c0h and e0h act alike
      dec.regHit = caNext[39:32] == 8'h00 && caNext[23:8] == 16'h0000 &&
         (caNext[7:0] == SEL_LOW_0 || caNext[7:0] == SEL_LOW_1) &&
         (caNext[31:24] == SEL_ID || caNext[31:24] == SEL_CFG) &&
         (dec.isRead ? ((top | 8'h20) == CMD_REG_READ_LIN)
                     : (top == CMD_REG_WRITE && caNext[31:24] == SEL_CFG));
      dec.regSel = {caNext[24], caNext[0]};
   end

   // reserved codes fall back to seven clocks, the reset latency, so a
   // wrong setting slows reads but never hangs them
   always_comb begin
      latCode = configWord0[CFG0_LAT_MSB:CFG0_LAT_LSB];
      case (latCode)
         4'h0: latClocks = 6'd5;
         4'h1: latClocks = 6'd6;
         4'he: latClocks = 6'd3;
         4'hf: latClocks = 6'd4;
         default: latClocks = 6'd7;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         caCnt_q <= 3'h0;
         ca_q <= '0;
         extraLat_q <= 1'b0;
         latCnt_q <= 6'h00;
         rdCnt_q <= 2'h0;
         wrHalf_q <= 1'b0;
         wrHi_q <= 8'h00;
         wrHit_q <= 1'b0;
      end else if (clkEn) begin
         if (!csActive) begin
            state_q <= ST_IDLE;
            caCnt_q <= 3'h0;
            wrHalf_q <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  state_q <= ST_CA;
                  caCnt_q <= 3'h0;
                  extraLat_q <= refreshBusy;
               end
               ST_CA: if (ckEdge) begin
                  ca_q <= caNext;
                  caCnt_q <= caCnt_q + 3'h1;
                  if (caLast) begin
                     // only a matching write may reach a register
                     wrHit_q <= dec.regHit;
                     if (!dec.isReg)
                        state_q <= ST_DONE;
                     else if (dec.isRead) begin
                        state_q <= ST_LAT;
                        // two counts when strobe showed refresh or fixed mode
                        latCnt_q <= (extraLat_q || configWord0[CFG0_FIXED_BIT])
                           ? 6'(2 * latClocks) : latClocks;
                     end else
                        state_q <= ST_WDATA;
                  end
               end
               ST_WDATA: begin
                  if (ckRise) begin
                     wrHi_q <= dqS2_q[7:0];
                     wrHalf_q <= 1'b1;
                  end
                  if (ckFall && wrHalf_q)
                     state_q <= ST_DONE;
               end
               ST_LAT: if (ckFall) begin
                  if (latCnt_q == 6'd1) begin
                     state_q <= ST_RDATA;
                     rdCnt_q <= 2'h0;
                  end else
                     latCnt_q <= latCnt_q - 6'd1;
               end
               ST_RDATA: if (ckEdge) begin
                  // further words repeat the same register; host reads one
                  rdCnt_q <= rdCnt_q + 2'h1;
               end
               ST_DONE: state_q <= ST_DONE;
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // register words
   // --------------------------------------------------------------
   wire logic wrStrobe = state_q == ST_WDATA && ckFall && wrHalf_q && csActive && wrHit_q;
   // identification words are constants: no write path reaches them
   wire logic [15:0] id0 = {ID0_DIE_ADDR, 1'b0, ID0_ROW_BITS,
      ID0_COL_BITS, MAKER_CODE};
   wire logic [15:0] id1 = {12'h000, DEVICE_TYPE};
   // a write lands on the falling edge that carries the low byte; the
   // upper byte was parked at the rising edge before it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         configWord0 <= CFG0_RESET;
         configWord1 <= CFG1_RESET;
      end else if (clkEn && wrStrobe) begin
         // full word, no mask; identification words have no write path
         if (ca_q[0] == 1'b0)
            configWord0 <= {wrHi_q, dqS2_q[7:0]};
         else
            configWord1 <= {wrHi_q, dqS2_q[7:0]};
      end
   end

   // the word is latched at the last address edge, so nothing that lands
   // during the latency can tear it
   always_ff @(posedge clk) begin
      if (!rst_n)
         rdWord_q <= 16'h0000;
      else if (clkEn && caLast && state_q == ST_CA && dec.isReg && dec.isRead) begin
         if (!dec.regHit)
            rdWord_q <= 16'h0000;
         else
            case (reg_sel_t'(dec.regSel))
               REG_ID0: rdWord_q <= id0;
               REG_ID1: rdWord_q <= id1;
               REG_CFG0: rdWord_q <= configWord0;
               REG_CFG1: rdWord_q <= configWord1;
               default: rdWord_q <= 16'h0000;
            endcase
      end
   end

   // --------------------------------------------------------------
   // strobe pin
   // --------------------------------------------------------------
   // refresh shown only during address cycles, then the pin is released;
   // during read data the strobe output follows the link clock level but the enable stays low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rwDataStrobeOut <= 1'b0;
         rwDataStrobeOe <= 1'b0;
      end else if (clkEn) begin
         rwDataStrobeOe <= csActive && state_q inside {ST_IDLE, ST_CA};
         rwDataStrobeOut <= csActive && (state_q == ST_RDATA ? ck : extraLat_q);
      end
   end

   // --------------------------------------------------------------
   // low data lane
   // --------------------------------------------------------------
   // the byte follows the synchronised clock level and lags the pin by three
   // device clocks; the host must sample late in each link half cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dqOut <= 8'h00;
         dqOe <= 1'b0;
      end else if (clkEn) begin
         dqOe <= csActive && state_q == ST_RDATA;
         dqOut <= (state_q == ST_RDATA && ck) ? rdWord_q[15:8] : rdWord_q[7:0];
      end
   end

   // --------------------------------------------------------------
   // array address
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         memAddr <= '0;
         memStart <= 1'b0;
         memIsRead <= 1'b0;
      end else if (clkEn) begin
         memStart <= 1'b0;
         if (state_q == ST_CA && caLast && !dec.isReg) begin
            memStart <= 1'b1;
            memIsRead <= dec.isRead;
            memAddr.row <= caNext[ROW_MSB:ROW_LSB];
            memAddr.halfPage <= caNext[HP_MSB:HP_LSB];
            memAddr.word <= caNext[WORD_MSB:WORD_LSB];
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/dram_regs_pkg.sv
/*
 holds constants and carrier types of the register-space access block.
 assumes one clock domain on the device side; the link clock is sampled.
*/
`default_nettype none
package dram_regs_pkg;
   // --------------------------------------------------------------
   // command/address word fields
   // --------------------------------------------------------------
   localparam int CA_WIDTH = 48;
   localparam int CA_READ_BIT = 47;
   localparam int CA_SPACE_BIT = 46;
   localparam int CA_BURST_BIT = 45;
   localparam int HP_MSB = 20;
   localparam int HP_LSB = 16;
   localparam int WORD_MSB = 2;
   localparam int WORD_LSB = 0;
   localparam int ROW_MSB = 35;
   localparam int ROW_LSB = 21;
   localparam int HALF_PAGES_PER_ROW = 32;
   localparam int WORDS_PER_HALF_PAGE = 8;
   localparam int DWORDS_PER_ROW = HALF_PAGES_PER_ROW * WORDS_PER_HALF_PAGE;
   localparam logic [7:0] CMD_REG_READ_WRAP = 8'hc0;
   localparam logic [7:0] CMD_REG_READ_LIN = 8'he0;
   localparam logic [7:0] CMD_REG_WRITE = 8'h60;
   localparam logic [7:0] SEL_ID = 8'h00;
   localparam logic [7:0] SEL_CFG = 8'h01;
   localparam logic [7:0] SEL_LOW_0 = 8'h00;
   localparam logic [7:0] SEL_LOW_1 = 8'h01;
   // --------------------------------------------------------------
   // register layouts and reset values
   // --------------------------------------------------------------
   localparam logic [1:0] ID0_DIE_ADDR = 2'h0;
   localparam logic [4:0] ID0_ROW_BITS = 5'h0e;
   localparam logic [3:0] ID0_COL_BITS = 4'h7;
   localparam logic [15:0] CFG0_RESET = 16'h8f2f;
   localparam logic [15:0] CFG1_RESET = 16'h0001;
   localparam int CFG0_LAT_MSB = 7;
   localparam int CFG0_LAT_LSB = 4;
   localparam int CFG0_FIXED_BIT = 3;
   localparam int CAW_CYCLES = 3;

   typedef struct packed {
      logic [14:0] row;
      logic [4:0] halfPage;
      logic [2:0] word;
   } mem_addr_t;

   typedef struct packed {
      logic valid;
      logic isRead;
      logic isReg;
      logic [1:0] regSel; // 0 id0, 1 id1, 2 cfg0, 3 cfg1
      logic regHit;
   } cmd_decode_t;

   typedef enum logic [1:0] { REG_ID0, REG_ID1, REG_CFG0, REG_CFG1 } reg_sel_t;
endpackage
`default_nettype wire

// ===== test/dram_access_properties.sv
/*
 concurrent checks on the register-space access block, bound to its ports.
 assumes link clock and chip select are seen raw, ahead of the block's synchronisers.
*/
`default_nettype none
module dram_access_properties
   import dram_regs_pkg::*;
(
   input wire logic clk, // device clock
   input wire logic rst_n, // sync reset
   input wire logic linkClk, // raw link clock
   input wire logic chipSelect_n, // raw chip select
   input wire logic dqOe, // low lane enable
   input wire logic rwDataStrobeOe, // strobe enable
   input wire logic memStart, // array start pulse
   input wire logic [15:0] configWord0, // config word 0
   input wire logic [15:0] configWord1 // config word 1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] csHigh_q;
   logic [5:0] edges_q;
   logic linkPrev_q;
   // counters saturate so long idle spells never wrap back into range
   always_ff @(posedge clk) begin
      if (!rst_n || !chipSelect_n) csHigh_q <= 4'h0;
      else if (csHigh_q != 4'hf) csHigh_q <= csHigh_q + 4'h1;
   end
   always_ff @(posedge clk) begin
      linkPrev_q <= linkClk;
      if (!rst_n || chipSelect_n) edges_q <= 6'h00;
      else if (linkClk != linkPrev_q && edges_q != 6'h3f) edges_q <= edges_q + 6'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_defaults: assert property (disable iff (1'b0)
      !rst_n |=> configWord0 == CFG0_RESET && configWord1 == CFG1_RESET && !dqOe)
      else $error("defaults not loaded by reset");
   a_mem_pulse: assert property (memStart |=> !memStart)
      else $error("array start longer than a cycle");
   a_mem_after_ca: assert property (memStart |-> edges_q >= 6'h06)
      else $error("array start before address complete");
   a_strobe_lane: assert property (!(rwDataStrobeOe && dqOe))
      else $error("strobe driven during data");
   a_strobe_in_ca: assert property (rwDataStrobeOe |-> edges_q <= 6'h07)
      else $error("strobe held past address cycles");
   a_lane_quiet: assert property (dqOe |-> csHigh_q < 4'h4)
      else $error("low lane driven outside frame");
   a_read_latency: assert property ($rose(dqOe) |-> edges_q >= 6'h0c)
      else $error("read data before latency");
   a_write_in_frame: assert property ($past(rst_n) && (configWord0 != $past(configWord0)
      || configWord1 != $past(configWord1)) |-> csHigh_q < 4'h8)
      else $error("config changed outside a write");
endmodule
bind dram_register_space_access dram_access_properties u_props (.clk(clk), .rst_n(rst_n),
   .linkClk(linkClk), .chipSelect_n(chipSelect_n), .dqOe(dqOe), .rwDataStrobeOe(rwDataStrobeOe),
   .memStart(memStart), .configWord0(configWord0), .configWord1(configWord1));
`default_nettype wire

// ===== test/host_link_model.sv
/*
 host model: drives chip select, the link clock and the data lanes.
 assumes a 50 ns device clock; a link half period is four device clocks.
*/
`default_nettype none
module host_link_model (
   input wire logic clk, // device clock
   output logic linkClk, // link clock, low between frames
   output logic chipSelect_n, // chip select
   output logic [15:0] dqIn, // lanes toward device
   input wire logic [7:0] dqOut, // device low lane
   input wire logic dqOe // device lane enable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rdWord;
   logic rdGot, rdDone;
   initial begin
      linkClk = 1'b0;
      chipSelect_n = 1'b1;
      dqIn = 16'h0000;
   end
   task automatic halfCycle(input logic [7:0] b);
      dqIn = {8'h5a, b};
      repeat (2) @(negedge clk);
      if (linkClk && dqOe && !rdGot) begin
         rdWord[15:8] = dqOut;
         rdGot = 1'b1;
      end else if (!linkClk && rdGot && !rdDone) begin
         rdWord[7:0] = dqOut;
         rdDone = 1'b1;
      end
      linkClk = ~linkClk;
      repeat (2) @(negedge clk);
   endtask
   // only the first read word is taken; later ones are not defined
   task automatic frame(input logic [47:0] ca, input int halves, input logic [15:0] wr);
      rdGot = 1'b0;
      rdDone = 1'b0;
      chipSelect_n = 1'b0;
      for (int i = 5; i >= 0; i--) begin
         halfCycle(ca[i*8+:8]);
      end
      for (int i = 0; i < halves && !rdDone; i++) begin
         halfCycle(i[0] ? wr[7:0] : wr[15:8]);
      end
      if (linkClk) begin
         halfCycle(8'h00);
      end
      chipSelect_n = 1'b1;
      dqIn = ~dqIn; // released lanes do not keep their last value
      repeat (6) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
/*
 self-checking bench for the register-space access block.
 assumes the host model in host_link_model and the bound checker.
*/
`default_nettype none
module tb;
   import dram_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ID0_WANT = {ID0_DIE_ADDR, 1'b0, ID0_ROW_BITS, ID0_COL_BITS, 4'h5};
   logic clk, rst_n, clkEn, refreshBusy, linkClk, chipSelect_n, dqOe, memStart, memIsRead;
   logic rwDataStrobeOut, rwDataStrobeOe, strobeWire;
   logic [15:0] dqIn, configWord0, configWord1;
   logic [7:0] dqOut, rdCmd;
   mem_addr_t memAddr;
   int err_count, comparisons, cycles;
   assign strobeWire = rwDataStrobeOe ? rwDataStrobeOut : ~rwDataStrobeOut;
   dram_register_space_access u_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .linkClk(linkClk),
      .chipSelect_n(chipSelect_n), .dqIn(dqIn), .rwDataStrobeIn(strobeWire),
      .refreshBusy(refreshBusy), .dqOut(dqOut), .dqOe(dqOe), .rwDataStrobeOut(rwDataStrobeOut),
      .rwDataStrobeOe(rwDataStrobeOe), .memAddr(memAddr), .memStart(memStart),
      .memIsRead(memIsRead), .configWord0(configWord0), .configWord1(configWord1));
   host_link_model u_host (.clk(clk), .linkClk(linkClk), .chipSelect_n(chipSelect_n),
      .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
   function automatic logic [47:0] regCa(input logic [7:0] top, input logic [7:0] sel,
      input logic [7:0] low);
      return {top, 8'h00, sel, 16'h0000, low};
   endfunction
   task automatic check(input logic [47:0] seen, input logic [47:0] want);
      comparisons++;
      if (seen !== want) begin
         err_count++;
         $display("BAD t=%0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic regRead(input logic [47:0] ca, input logic [15:0] want);
      u_host.frame(ca, 40, 16'h0000);
      check(u_host.rdDone, 1'b1);
      check(u_host.rdWord, want);
   endtask
   task automatic memAccess(input logic isRd, input logic [14:0] row, input logic [4:0] hp,
      input logic [2:0] w);
      u_host.frame({isRd, 2'b01, 9'h000, row, hp, 13'h0000, w}, 4, 16'h0000);
      check(memAddr, {row, hp, w});
      check(memIsRead, isRd);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         err_count++;
         final_report;
      end
   end
   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      refreshBusy = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      check(configWord0, CFG0_RESET);
      check(configWord1, CFG1_RESET);
      @(negedge clk);
      for (int t = 0; t < 2; t++) begin
         rdCmd = t ? CMD_REG_READ_LIN : CMD_REG_READ_WRAP;
         regRead(regCa(rdCmd, SEL_ID, SEL_LOW_0), ID0_WANT);
         check(u_host.rdWord[12:8] + u_host.rdWord[7:4] + 2, 23);
         regRead(regCa(rdCmd, SEL_ID, SEL_LOW_1), 16'h0003);
         regRead(regCa(rdCmd, SEL_CFG, SEL_LOW_0), CFG0_RESET);
      end
      $display("test identification reads done");
      refreshBusy = 1'b1; // refresh flagged while the write address arrives
      u_host.frame(regCa(CMD_REG_WRITE, SEL_CFG, SEL_LOW_0), 2, 16'h8fe7);
      check(configWord0, 16'h8fe7);
      regRead(regCa(CMD_REG_READ_WRAP, SEL_CFG, SEL_LOW_0), 16'h8fe7);
      refreshBusy = 1'b0;
      u_host.frame(regCa(CMD_REG_WRITE, SEL_CFG, SEL_LOW_1), 2, 16'h0002);
      check(configWord1, 16'h0002);
      regRead(regCa(CMD_REG_READ_LIN, SEL_CFG, SEL_LOW_1), 16'h0002);
      u_host.frame(regCa(CMD_REG_WRITE, SEL_ID, SEL_LOW_0), 2, 16'h1234);
      check(configWord0, 16'h8fe7);
      regRead(regCa(CMD_REG_READ_LIN, SEL_ID, SEL_LOW_0), ID0_WANT);
      $display("test register writes done");
      memAccess(1'b1, 15'h5a3c, 5'h13, 3'h5);
      memAccess(1'b0, 15'h7fff, 5'h1f, 3'h7);
      check(configWord0, 16'h8fe7);
      $display("test array decode done");
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      check(configWord0, CFG0_RESET);
      @(negedge clk);
      regRead(regCa(CMD_REG_READ_WRAP, SEL_CFG, SEL_LOW_1), CFG1_RESET);
      $display("test second reset done");
      final_report;
   end
endmodule
`default_nettype wire
